// ---- afc_defines.vh ----
/*
 constants for the asynchronous fifo host controller
 assumes a 125 MHz pclk and an apb master in software
*/
`ifndef AFC_DEFINES_VH
`define AFC_DEFINES_VH
// ==========================================================
// register offsets
`define AFC_CTRL_OFF      12'h000
`define AFC_STAT_OFF      12'h004
`define AFC_WDATA_OFF     12'h008
`define AFC_RDATA_OFF     12'h00C
// ==========================================================
// control fields
`define AFC_CTRL_CLEAR    0
`define AFC_CTRL_REPLAY   1
`define AFC_CTRL_CHAIN    2
`define AFC_CTRL_FIRST    3
// ==========================================================
// status fields
`define AFC_STAT_BUSY     0
`define AFC_STAT_FULL     1
`define AFC_STAT_EMPTY    2
`define AFC_STAT_HALF     3
`define AFC_STAT_RVALID   4
`define AFC_STAT_ERR      5
// ==========================================================
// timing, ns and cycles at 8 ns
`define AFC_CLK_NS        8
`define AFC_PULSE_NS      80
`define AFC_PULSE_CYC     ((`AFC_PULSE_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RECOV_NS      80
`define AFC_RECOV_CYC     ((`AFC_RECOV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_CTRL_RST      4'h0
`endif

// ---- afc_sync.v ----
/*
 two flop synchroniser for one pin
 assumes d is asynchronous to pclk
*/
`timescale 1ns/1ps
module afc_sync
#(
   parameter [0:0] RST_VAL = 1'b1
)
(
   input  wire pclk,
   input  wire presetn,
   input  wire d,
   output wire q
);
   reg s1_r;
   reg s2_r;
   // ==========================================================
   // reset level is chosen per pin; the empty flag starts at its safe side, full and half start high
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule // afc_sync

// ---- afc_timer.v ----
/*
 down counter for strobe low and high times
 assumes load is a one cycle request
*/
`timescale 1ns/1ps
module afc_timer
#(
   parameter W = 8
)
(
   input  wire         pclk,
   input  wire         presetn,
   input  wire         load,
   input  wire [W-1:0] val,
   output wire         done
);
   reg [W-1:0] cnt_r;
   // ==========================================================
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= {W{1'b0}};
      else if (load)
         cnt_r <= val;
      else if (cnt_r != {W{1'b0}})
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
   end
   assign done = (cnt_r == {W{1'b0}}) && !load;
endmodule // afc_timer

// ---- afc_host.v ----
/*
 host controller driving one fifo device through its strobes
 assumes apb software master, fifo pins asynchronous to pclk
*/
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "afc_defines.vh"
module afc_host
#(
   parameter DW = 9,
   parameter TW = 8
)
(
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   output reg           put_pulse_n,
   output reg           get_pulse_n,
   output reg           clear_n,
   output reg           first_load_or_replay,
   output reg           chain_in_sel,
   output reg  [DW-1:0] fifo_wdata,
   output reg           fifo_wdata_oe,
   input  wire [DW-1:0] fifo_rdata,
   input  wire          full_flag,
   input  wire          empty_flag,
   input  wire          chain_out_or_half_flag
);
   // ==========================================================
   // states
   localparam S_IDLE  = 3'h0;
   localparam S_LOW   = 3'h1;
   localparam S_HIGH  = 3'h2;
   localparam S_WAITF = 3'h3;
   localparam OP_WR   = 2'h0;
   localparam OP_RD   = 2'h1;
   localparam OP_CLR  = 2'h2;
   localparam OP_RPL  = 2'h3;
   // counts are whole-cycle ceilings; the timer width must hold them
   localparam integer  PULSE_I   = `AFC_PULSE_CYC;
   localparam integer  RECOV_I   = `AFC_RECOV_CYC;
   localparam [TW-1:0] PULSE_CYC = PULSE_I[TW-1:0];
   localparam [TW-1:0] RECOV_CYC = RECOV_I[TW-1:0];

   reg  [2:0]    st_r;
   reg  [1:0]    op_r;
   reg  [3:0]    ctrl_r;
   reg  [DW-1:0] rbuf_r;
   reg           rvalid_r;
   reg           err_r;
   reg           tload;
   reg  [TW-1:0] tval;
   wire          tdone;
   wire          ff_s;
   wire          ef_s;
   wire          hf_s;
   wire [DW-1:0] rd_s;
   wire          setup;
   wire          busy;

   // ==========================================================
   // pin synchronisers, one per flag and one per data bit
   // flags come from any one device of a width array, or from the
   // board's or of the flags of every chained device
   afc_sync
   #(
      .RST_VAL (1'b1)
   )
   u_ff
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (full_flag),
      .q       (ff_s)
   );
   // empty until the device shows data, so no read slips out early
   afc_sync
   #(
      .RST_VAL (1'b0)
   )
   u_ef
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (empty_flag),
      .q       (ef_s)
   );
   afc_sync
   #(
      .RST_VAL (1'b1)
   )
   u_hf
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (chain_out_or_half_flag),
      .q       (hf_s)
   );
   genvar gi;
   generate
      for (gi = 0; gi < DW; gi = gi + 1)
      begin : g_rd
         afc_sync
         #(
            .RST_VAL (1'b1)
         )
         u_rd
         (
            .pclk    (pclk),
            .presetn (presetn),
            .d       (fifo_rdata[gi]),
            .q       (rd_s[gi])
         );
      end
   endgenerate

   afc_timer #(.W(TW)) u_tmr (.pclk(pclk), .presetn(presetn),
      .load(tload), .val(tval), .done(tdone));

   assign setup = psel && !penable;
   assign busy  = (st_r != S_IDLE);

   // ==========================================================
   // apb slave: no wait states, pready in first access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (setup)
         begin
            case (paddr)
               `AFC_CTRL_OFF:  prdata <= {28'h0000000, ctrl_r};
               `AFC_STAT_OFF:  prdata <= {26'h0, err_r, rvalid_r,
                                  hf_s | ctrl_r[`AFC_CTRL_CHAIN], ef_s,
                                  ff_s, busy};
               `AFC_RDATA_OFF: prdata <= {{(32-DW){1'b0}}, rbuf_r};
               `AFC_WDATA_OFF: prdata <= 32'h0000_0000;
               default:        pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ==========================================================
   // strobe sequencer
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r        <= S_IDLE;
         op_r        <= OP_WR;
         ctrl_r      <= `AFC_CTRL_RST;
         rbuf_r      <= {DW{1'b0}};
         rvalid_r    <= 1'b0;
         err_r       <= 1'b0;
         put_pulse_n <= 1'b1;
         get_pulse_n <= 1'b1;
         clear_n     <= 1'b1;
         first_load_or_replay <= 1'b1;
         chain_in_sel  <= 1'b0;
         fifo_wdata    <= {DW{1'b0}};
         fifo_wdata_oe <= 1'b0;
         tload <= 1'b0;
         tval  <= {TW{1'b0}};
      end
      else
      begin
         tload <= 1'b0;
         chain_in_sel <= ctrl_r[`AFC_CTRL_CHAIN];
         if (st_r == S_IDLE)
            first_load_or_replay <= ctrl_r[`AFC_CTRL_CHAIN] ?
               ctrl_r[`AFC_CTRL_FIRST] : 1'b1;
         if (psel && penable && pready && pwrite && !pslverr)
         begin
            if (paddr == `AFC_CTRL_OFF)
            begin
               // a refused order leaves mode pins alone mid-strobe
               if (busy)
                  err_r <= 1'b1;
               else
               begin
                  ctrl_r <= pwdata[3:0];
                  if (pwdata[`AFC_CTRL_CLEAR])
                  begin
                     op_r <= OP_CLR;
                     st_r <= S_LOW;
                  end
                  else if (pwdata[`AFC_CTRL_REPLAY] &&
                           !pwdata[`AFC_CTRL_CHAIN])
                  begin
                     op_r <= OP_RPL;
                     st_r <= S_LOW;
                  end
               end
            end
            else if (paddr == `AFC_WDATA_OFF)
            begin
               if (busy || !ff_s)
                  err_r <= 1'b1;
               else
               begin
                  fifo_wdata <= pwdata[DW-1:0];
                  fifo_wdata_oe <= 1'b1;
                  op_r <= OP_WR;
                  st_r <= S_LOW;
               end
            end
            else if (paddr == `AFC_STAT_OFF)
               err_r <= 1'b0;
         end
         else if (psel && penable && pready && !pwrite &&
                  paddr == `AFC_RDATA_OFF)
         begin
            if (!busy && ef_s)
            begin
               op_r <= OP_RD;
               st_r <= S_LOW;
            end
            else if (!busy)
               err_r <= 1'b1;
            rvalid_r <= 1'b0;
         end
         case (st_r)
            S_IDLE:
            begin
               tload <= 1'b0;
            end
            S_LOW:
            begin
               case (op_r)
                  OP_WR:  put_pulse_n <= 1'b0;
                  OP_RD:  get_pulse_n <= 1'b0;
                  OP_CLR: clear_n <= 1'b0;
                  OP_RPL: first_load_or_replay <= 1'b0;
                  default: put_pulse_n <= 1'b1;
               endcase
               tval  <= PULSE_CYC;
               tload <= 1'b1;
               st_r  <= S_HIGH;
            end
            S_HIGH:
            begin
               if (tdone && !tload)
               begin
                  if (op_r == OP_RD)
                  begin
                     rbuf_r   <= rd_s;
                     rvalid_r <= 1'b1;
                  end
                  put_pulse_n <= 1'b1;
                  get_pulse_n <= 1'b1;
                  clear_n     <= 1'b1;
                  if (op_r == OP_RPL)
                     first_load_or_replay <= 1'b1;
                  tval  <= RECOV_CYC;
                  tload <= 1'b1;
                  st_r  <= S_WAITF;
               end
            end
            S_WAITF:
            begin
               if (tdone && !tload)
               begin
                  fifo_wdata_oe <= 1'b0;
                  st_r <= S_IDLE;
                  ctrl_r[`AFC_CTRL_CLEAR]  <= 1'b0;
                  ctrl_r[`AFC_CTRL_REPLAY] <= 1'b0;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule // afc_host

// ---- afc_checker.sv ----
/*
 port checker for afc_host
 assumes a single pclk domain and bind by name
*/
`timescale 1ns/1ps
module afc_checker
#(
   parameter DW = 9
)
(
   input wire          pclk,
   input wire          presetn,
   input wire          psel,
   input wire          penable,
   input wire          pready,
   input wire          put_pulse_n,
   input wire          get_pulse_n,
   input wire          clear_n,
   input wire          fifo_wdata_oe,
   input wire [DW-1:0] fifo_wdata
);
// =====
// properties
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
ready_after_setup_a: assert property (psel && !penable |=> pready)
   else $error("no ready after setup");
ready_single_a: assert property (pready |=> !pready)
   else $error("ready held too long");
put_width_a: assert property ($fell(put_pulse_n) |=> !put_pulse_n [*8])
   else $error("write strobe too short");
put_recover_a: assert property ($rose(put_pulse_n) |=> put_pulse_n [*8])
   else $error("write strobe recovery too short");
get_width_a: assert property ($fell(get_pulse_n) |=> !get_pulse_n [*8])
   else $error("read strobe too short");
one_strobe_a: assert property (!put_pulse_n |-> get_pulse_n)
   else $error("both strobes low");
put_drives_a: assert property (!put_pulse_n |-> fifo_wdata_oe)
   else $error("write data not driven");
wdata_hold_a: assert property (!put_pulse_n && !$past(put_pulse_n)
   |-> $stable(fifo_wdata)) else $error("write data moved");
clear_quiet_a: assert property (!clear_n |-> put_pulse_n && get_pulse_n)
   else $error("strobe during clear");
endmodule // afc_checker
bind afc_host afc_checker #(.DW(DW)) afc_checker_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .put_pulse_n(put_pulse_n), .get_pulse_n(get_pulse_n),
   .clear_n(clear_n), .fifo_wdata_oe(fifo_wdata_oe),
   .fifo_wdata(fifo_wdata));

// ---- afc_dev_model.sv ----
/*
 behavioural fifo device on the far side of afc_host
 assumes one strobe at a time and a small depth
*/
`timescale 1ns/1ps
module afc_dev_model
#(
   parameter DEPTH = 8
)
(
   input  wire       put_pulse_n,
   input  wire       get_pulse_n,
   input  wire       clear_n,
   input  wire       first_load_or_replay,
   input  wire       chain_in_sel,
   input  wire [8:0] fifo_wdata,
   output reg  [8:0] fifo_rdata,
   output wire       full_flag,
   output wire       empty_flag,
   output wire       chain_out_or_half_flag
);
// =====
// storage and flags
reg [8:0] mem [0:DEPTH-1];
integer   wp = 0, rp = 0, cnt = 0, tot = 0;
assign empty_flag = (cnt != 0);
assign full_flag = (cnt != DEPTH);
assign chain_out_or_half_flag = chain_in_sel ? (wp != DEPTH - 1)
   : (cnt <= DEPTH / 2);
initial fifo_rdata = 9'h000;
always @(negedge clear_n)
begin
   wp = 0; rp = 0; cnt = 0; tot = 0;
end
always @(posedge put_pulse_n)
   if (clear_n && cnt < DEPTH)
   begin
      mem[wp] = fifo_wdata;
      wp = (wp + 1) % DEPTH;
      cnt = cnt + 1;
      tot = tot + 1;
   end
always @(negedge get_pulse_n)
   if (cnt != 0) fifo_rdata = mem[rp];
// released bus shows the inverse, not a stale word
always @(posedge get_pulse_n)
   if (clear_n && cnt != 0)
   begin
      rp = (rp + 1) % DEPTH;
      cnt = cnt - 1;
      fifo_rdata = ~fifo_rdata;
   end
always @(negedge first_load_or_replay)
   if (!chain_in_sel && clear_n)
   begin
      rp = 0;
      cnt = (tot < DEPTH) ? tot : DEPTH;
   end
endmodule // afc_dev_model

// ---- testbench.sv ----
/*
 self-checking bench for afc_host
 assumes afc_dev_model with depth 8 as the device
*/
`timescale 1ns/1ps
`include "afc_defines.vh"
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module testbench;
localparam DEP = 8;
reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
reg  [11:0] paddr = 12'h000;
reg  [31:0] pwdata = 32'h00000000, r, v;
wire [31:0] prdata;
wire        pready, pslverr, pp_n, gp_n, clr_n, flr, cis, oe, ff, ef, hf;
wire [8:0]  wd, rd;
integer     fails = 0, checked = 0, i;
afc_host afc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .put_pulse_n(pp_n), .get_pulse_n(gp_n), .clear_n(clr_n),
   .first_load_or_replay(flr), .chain_in_sel(cis), .fifo_wdata(wd),
   .fifo_wdata_oe(oe), .fifo_rdata(rd), .full_flag(ff),
   .empty_flag(ef), .chain_out_or_half_flag(hf));
afc_dev_model #(.DEPTH(DEP)) afc_dev_model_i (.put_pulse_n(pp_n),
   .get_pulse_n(gp_n), .clear_n(clr_n), .first_load_or_replay(flr),
   .chain_in_sel(cis), .fifo_wdata(wd), .fifo_rdata(rd),
   .full_flag(ff), .empty_flag(ef), .chain_out_or_half_flag(hf));
// =====
// bus tasks
task apb(input [11:0] a, input w, input [31:0] d);
begin
   @(posedge pclk);
   psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
   @(posedge pclk);
   penable <= 1;
   @(posedge pclk);
   while (!pready) @(posedge pclk);
   r = prdata; e = pslverr;
   psel <= 0; penable <= 0;
end
endtask
// poll busy; a hang is cut by the watchdog
// v keeps the order's own answer; a read of rdata returns the word
// fetched by the previous read and starts fetching the next one
task cmd(input [11:0] a, input w, input [31:0] d);
begin
   apb(a, w, d);
   v = r;
   r = 32'h00000001;
   while (r[`AFC_STAT_BUSY]) apb(`AFC_STAT_OFF, 0, 32'h00000000);
end
endtask
task clr;
begin
   cmd(`AFC_CTRL_OFF, 1, 32'h00000001);
   cmd(`AFC_CTRL_OFF, 1, 32'h00000000);
   `CHK(afc_dev_model_i.cnt, 0)
   apb(`AFC_STAT_OFF, 0, 32'h00000000);
   `CHK(r[3:1], 3'h5)
   apb(`AFC_STAT_OFF, 1, 32'h00000000);
end
endtask
// =====
// scenarios
task t_order;
begin
   clr;
   for (i = 0; i < 3; i++) cmd(`AFC_WDATA_OFF, 1, 32'h000000A0 + i);
   cmd(`AFC_RDATA_OFF, 0, 32'h00000000);
   for (i = 0; i < 3; i++)
   begin
      cmd(`AFC_RDATA_OFF, 0, 32'h00000000);
      `CHK(v[8:0], 9'h0A0 + i)
   end
   apb(`AFC_STAT_OFF, 0, 32'h00000000);
   `CHK(r[`AFC_STAT_ERR], 1'h1)
   `CHK(r[`AFC_STAT_EMPTY], 1'h0)
   apb(`AFC_STAT_OFF, 1, 32'h00000000);
   $display("test order done");
end
endtask
task t_full;
begin
   clr;
   for (i = 0; i < DEP; i++) cmd(`AFC_WDATA_OFF, 1, 32'h00000100 + i);
   apb(`AFC_STAT_OFF, 0, 32'h00000000);
   `CHK(r[`AFC_STAT_HALF], 1'h0)
   `CHK(r[`AFC_STAT_FULL], 1'h0)
   cmd(`AFC_WDATA_OFF, 1, 32'h00000055);
   `CHK(afc_dev_model_i.cnt, DEP)
   apb(`AFC_STAT_OFF, 0, 32'h00000000);
   `CHK(r[`AFC_STAT_ERR], 1'h1)
   apb(`AFC_STAT_OFF, 1, 32'h00000000);
   $display("test full done");
end
endtask
task t_replay;
begin
   clr;
   cmd(`AFC_WDATA_OFF, 1, 32'h00000011);
   cmd(`AFC_WDATA_OFF, 1, 32'h00000022);
   cmd(`AFC_RDATA_OFF, 0, 32'h00000000);
   cmd(`AFC_RDATA_OFF, 0, 32'h00000000);
   `CHK(v[8:0], 9'h011)
   cmd(`AFC_CTRL_OFF, 1, 32'h00000002);
   cmd(`AFC_CTRL_OFF, 1, 32'h00000000);
   cmd(`AFC_RDATA_OFF, 0, 32'h00000000);
   cmd(`AFC_RDATA_OFF, 0, 32'h00000000);
   `CHK(v[8:0], 9'h011)
   cmd(`AFC_RDATA_OFF, 0, 32'h00000000);
   `CHK(v[8:0], 9'h022)
   $display("test replay done");
end
endtask
task t_mode;
begin
   cmd(`AFC_CTRL_OFF, 1, 32'h00000004);
   `CHK({cis, flr}, 2'h2)
   apb(`AFC_CTRL_OFF, 1, 32'h00000006);
   apb(`AFC_STAT_OFF, 0, 32'h00000000);
   `CHK(r[`AFC_STAT_BUSY], 1'h0)
   `CHK({cis, flr}, 2'h2)
   cmd(`AFC_CTRL_OFF, 1, 32'h0000000C);
   `CHK({cis, flr}, 2'h3)
   cmd(`AFC_CTRL_OFF, 1, 32'h00000000);
   `CHK(cis, 1'h0)
   apb(12'h010, 0, 32'h00000000);
   `CHK(e, 1'h1)
   $display("test mode done");
end
endtask
task complete_run;
begin
   $display("checked %0d fails %0d", checked, fails);
   if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
end
endtask
initial forever #4 pclk = ~pclk;
initial
begin
   #400000;
   fails++;
   complete_run;
end
initial
begin
   repeat (4) @(posedge pclk);
   presetn <= 1;
   t_order;
   t_full;
   t_replay;
   t_mode;
   complete_run;
end
endmodule // testbench
